/* diei_dbn_if.sv */
// Interface carrying raw inputs, filter settings and filtered inputs.
`timescale 1ns/1ns
interface diei_dbn_if #(
  parameter int NCH = 16,
  parameter int PW = 8
);
  logic [NCH-1:0] raw;      // Input word taken over from the link side.
  logic enable;             // Filter on when high.
  logic [PW-1:0] preload;   // Shared filter length in steps minus one.
  logic [NCH-1:0] clean;    // Filtered input word.
  modport filt (input raw, input enable, input preload, output clean);
  modport ctrl (output raw, output enable, output preload, input clean);
endinterface : diei_dbn_if

/* diei_debounce.sv */
// Shared-time debounce filter for all input channels.
`timescale 1ns/1ns
module diei_debounce #(
  parameter int NCH = 16,
  parameter int PW = 8,
  parameter int STEP_CYC = 22500
) (
  input wire logic mclk,
  input wire logic rstn,
  diei_dbn_if.filt f
);

  // ----------------------------------------------------------------------
  // Checks and sizes.
  // ----------------------------------------------------------------------
  localparam int PSW = $clog2(STEP_CYC);  // Prescaler width.

  if (STEP_CYC < 2 || NCH < 1 || PW < 1) begin : g_bad
    $error("diei_debounce: unsupported parameter values");
  end

  logic [PSW-1:0] pre_reg;           // Step prescaler.
  logic tick;                        // One pulse per step.
  logic [PW-1:0] cnt_reg [NCH];      // Per-channel elapsed steps.
  logic [NCH-1:0] clean_reg;         // Accepted input levels.

  assign tick = (pre_reg == PSW'(STEP_CYC - 1));
  assign f.clean = clean_reg;

  // Free-running step prescaler shared by every channel.
  always_ff @(posedge mclk) begin
    if (!rstn || tick) begin
      pre_reg <= '0;
    end else begin
      pre_reg <= pre_reg + 1'b1;
    end
  end

  // A changed level is accepted after preload plus one steps.
  // One preload and one prescaler serve all channels.
  always_ff @(posedge mclk) begin
    for (int i = 0; i < NCH; i++) begin
      if (!rstn) begin
        cnt_reg[i] <= '0;
        clean_reg[i] <= 1'b0;
      end else if (!f.enable) begin
        // Filter bypassed: input passes straight through.
        cnt_reg[i] <= '0;
        clean_reg[i] <= f.raw[i];
      end else if (f.raw[i] == clean_reg[i]) begin
        cnt_reg[i] <= '0;
      end else if (tick) begin
        if (cnt_reg[i] == f.preload) begin
          clean_reg[i] <= f.raw[i];
          cnt_reg[i] <= '0;
        end else begin
          cnt_reg[i] <= cnt_reg[i] + 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------------
  chk_bypass_follow: assert property (@(posedge mclk) disable iff (!rstn)
    !f.enable |=> clean_reg == $past(f.raw))
    else $error("bypassed filter did not follow input");

  chk_accept_time: assert property (@(posedge mclk) disable iff (!rstn)
    (f.enable && tick && f.raw[0] != clean_reg[0] && cnt_reg[0] == f.preload)
    |=> clean_reg[0] == $past(f.raw[0]))
    else $error("filtered level not accepted at end of time");

endmodule : diei_debounce

/* diei_pkg.sv */
// Package of constants shared by the debounced input edge interrupt block.
package diei_pkg;

  // ----------------------------------------------------------------------
  // Sizes.
  // ----------------------------------------------------------------------
  localparam int NUM_CH = 16;        // Number of input channels.
  localparam int PRE_W = 8;          // Width of the debounce preload.

  // ----------------------------------------------------------------------
  // Word indexes in I/O space (address lines 6..1).
  // ----------------------------------------------------------------------
  localparam logic [5:0] IDX_INPUT = 6'h00;  // Input state word.
  localparam logic [5:0] IDX_GCTL = 6'h01;   // Global control, low byte.
  localparam logic [5:0] IDX_RISE_EN = 6'h02;  // Rising edge enables.
  localparam logic [5:0] IDX_FALL_EN = 6'h03;  // Falling edge enables.
  localparam logic [5:0] IDX_RISE_PND = 6'h04;  // Rising edge pending.
  localparam logic [5:0] IDX_FALL_PND = 6'h05;  // Falling edge pending.
  localparam logic [5:0] IDX_VEC = 6'h06;    // Interrupt vector, low byte.
  localparam logic [5:0] IDX_PRE = 6'h07;    // Debounce preload, low byte.

  // ----------------------------------------------------------------------
  // Global control bit positions.
  // ----------------------------------------------------------------------
  localparam int GC_GIE = 0;         // Global interrupt enable.
  localparam int GC_SPARE = 1;       // Bit without function.
  localparam int GC_DEB = 2;         // Debounce enable.
  localparam int GC_PEND = 7;        // Any request pending.

  // ----------------------------------------------------------------------
  // Reset values.
  // ----------------------------------------------------------------------
  localparam logic [15:0] RST_EN = 16'h0000;   // Edge enables.
  localparam logic [15:0] RST_PND = 16'h0000;  // Pending flags.
  localparam logic [7:0] RST_BYTE = 8'h00;     // Vector and preload.

  // ----------------------------------------------------------------------
  // Timing.
  // ----------------------------------------------------------------------
  localparam int CLK_MHZ = 25;       // Register clock rate in MHz.
  localparam int DEB_STEP_US = 900;  // One debounce step in microseconds.
  localparam int DEB_STEP_CYC = DEB_STEP_US * CLK_MHZ;  // Step in cycles.

  // ----------------------------------------------------------------------
  // Bus cycle states.
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    DIEI_BUS_IDLE = 2'b00,
    DIEI_BUS_ACK = 2'b01,
    DIEI_BUS_HOLD = 2'b10
  } diei_bus_type;

endpackage : diei_pkg

/* diei_src_model.sv */
// Model of the input source that drives the sixteen raw input lines.
`timescale 1ns/1ns
module diei_src_model (
  input wire logic lclk,
  input wire logic [15:0] level,
  output logic [15:0] din
);
  // ------------------------------------------------------------------
  // Line drive.
  // ------------------------------------------------------------------
  // The wanted levels reach the lines only on a link clock edge.
  // The change therefore lands unrelated in phase to the register clock.
  always @(posedge lclk) begin
    din <= level;
  end
endmodule : diei_src_model

/* diei_top.sv */
// Sixteen-channel debounced input block with edge interrupts on the IP bus.
`timescale 1ns/1ns
module diei_top #(
  parameter int NCH = diei_pkg::NUM_CH,
  parameter int STEP_CYC = diei_pkg::DEB_STEP_CYC
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic lclk,
  input wire logic [NCH-1:0] din,
  input wire logic io_sel_n,
  input wire logic int_sel_n,
  input wire logic rd_wr,
  input wire logic [5:0] addr,
  input wire logic [15:0] data_in,
  output logic [15:0] data_out,
  output logic data_oe,
  output logic ack_n,
  output logic intreq0_n
);

  // ----------------------------------------------------------------------
  // Parameter check.
  // ----------------------------------------------------------------------
  if (NCH != 16) begin : g_bad
    $error("diei_top: register map serves exactly sixteen channels");
  end

  // True when the current word address selects the given register.
  function automatic logic hit(input logic [5:0] a, input logic [5:0] idx);
    hit = (a == idx);
  endfunction : hit

  // ----------------------------------------------------------------------
  // Link domain: pin sampling and word hand-off.
  // ----------------------------------------------------------------------
  logic [1:0] lrst_reg;              // Reset brought into the link domain.
  logic [NCH-1:0] pin1_reg;          // First pin synchroniser stage.
  logic [NCH-1:0] pin2_reg;          // Second pin synchroniser stage.
  logic [NCH-1:0] hold_reg;          // Word offered to the register side.
  logic req_tgl_reg;                 // Toggles when a new word is offered.
  logic ack1_reg;                    // First stage of returned toggle.
  logic ack2_reg;                    // Second stage of returned toggle.
  logic ack_tgl_reg;                 // Toggle returned to the link side.

  // Reset release follows the link clock into the link domain.
  always_ff @(posedge lclk) begin
    lrst_reg <= {lrst_reg[0], rstn};
  end

  // Input pins are asynchronous, so they pass two flops first.
  always_ff @(posedge lclk) begin
    pin1_reg <= din;
    pin2_reg <= pin1_reg;
  end

  // Returned toggle passes two flops before it is compared.
  always_ff @(posedge lclk) begin
    if (!lrst_reg[1]) begin
      ack1_reg <= 1'b0;
      ack2_reg <= 1'b0;
    end else begin
      ack1_reg <= ack_tgl_reg;
      ack2_reg <= ack1_reg;
    end
  end

  // A new word is offered only after the last one was taken, so the
  // held word never changes while the register side samples it.
  always_ff @(posedge lclk) begin
    if (!lrst_reg[1]) begin
      hold_reg <= '0;
      req_tgl_reg <= 1'b0;
    end else if (req_tgl_reg == ack2_reg) begin
      hold_reg <= pin2_reg;
      req_tgl_reg <= ~req_tgl_reg;
    end
  end

  // ----------------------------------------------------------------------
  // Register domain: word take-over.
  // ----------------------------------------------------------------------
  logic req1_reg;                    // First stage of offered toggle.
  logic req2_reg;                    // Second stage of offered toggle.
  logic req3_reg;                    // Delayed copy for change detect.
  logic [NCH-1:0] raw_reg;           // Latest input word, register side.

  // Offered toggle is synchronised before its change is detected.
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      req1_reg <= 1'b0;
      req2_reg <= 1'b0;
      req3_reg <= 1'b0;
    end else begin
      req1_reg <= req_tgl_reg;
      req2_reg <= req1_reg;
      req3_reg <= req2_reg;
    end
  end

  // On a toggle change the held word is stable and is copied.
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      raw_reg <= '0;
      ack_tgl_reg <= 1'b0;
    end else if (req2_reg != req3_reg) begin
      raw_reg <= hold_reg;
      ack_tgl_reg <= req2_reg;
    end
  end

  // ----------------------------------------------------------------------
  // Registers.
  // ----------------------------------------------------------------------
  logic gie_reg;                     // Global interrupt enable.
  logic deb_en_reg;                  // Debounce enable.
  logic [NCH-1:0] rise_irq_enable_reg;  // Rising edge enables.
  logic [NCH-1:0] fall_irq_enable_reg;  // Falling edge enables.
  logic [NCH-1:0] rise_irq_pending_reg;  // Rising edge pending flags.
  logic [NCH-1:0] fall_irq_pending_reg;  // Falling edge pending flags.
  logic [7:0] irq_vector_reg;        // Interrupt vector.
  logic [7:0] debounce_preload_reg;  // Shared debounce preload.
  logic [NCH-1:0] clean_prev_reg;    // Filtered word one cycle ago.
  logic [NCH-1:0] rise_set;          // Enabled rising edges this cycle.
  logic [NCH-1:0] fall_set;          // Enabled falling edges this cycle.
  logic [NCH-1:0] rise_next;         // Next rising pending word.
  logic [NCH-1:0] fall_next;         // Next falling pending word.
  logic any_pend;                    // Some request is pending.
  logic take;                        // Bus cycle accepted this edge.
  logic wr_io;                       // Accepted I/O write.
  logic [15:0] rdata;                // Read data for this cycle.

  // Filter settings and filtered word travel in one interface.
  diei_dbn_if #(.NCH(NCH), .PW(diei_pkg::PRE_W)) dbn ();

  assign dbn.raw = raw_reg;
  assign dbn.enable = deb_en_reg;
  assign dbn.preload = debounce_preload_reg;

  diei_debounce #(
    .NCH(NCH),
    .PW(diei_pkg::PRE_W),
    .STEP_CYC(STEP_CYC)
  ) u_deb (
    .mclk(mclk),
    .rstn(rstn),
    .f(dbn.filt)
  );

  // Edges are found on the filtered word and gated per channel.
  assign rise_set = dbn.clean & ~clean_prev_reg & rise_irq_enable_reg;
  assign fall_set = ~dbn.clean & clean_prev_reg & fall_irq_enable_reg;

  // Write-one clears a flag, but a new edge in the same cycle wins.
  assign rise_next = (rise_irq_pending_reg
                      & ~((wr_io && hit(addr, diei_pkg::IDX_RISE_PND)) ? data_in : 16'h0000))
                     | rise_set;
  assign fall_next = (fall_irq_pending_reg
                      & ~((wr_io && hit(addr, diei_pkg::IDX_FALL_PND)) ? data_in : 16'h0000))
                     | fall_set;
  assign any_pend = |{rise_irq_pending_reg, fall_irq_pending_reg};

  // Previous filtered word for edge detection.
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      clean_prev_reg <= '0;
    end else begin
      clean_prev_reg <= dbn.clean;
    end
  end

  // Pending flags, cleared by reset.
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      rise_irq_pending_reg <= diei_pkg::RST_PND;
      fall_irq_pending_reg <= diei_pkg::RST_PND;
    end else begin
      rise_irq_pending_reg <= rise_next;
      fall_irq_pending_reg <= fall_next;
    end
  end

  // Writable registers; bit one and bits six to three are dropped.
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      gie_reg <= 1'b0;
      deb_en_reg <= 1'b0;
      rise_irq_enable_reg <= diei_pkg::RST_EN;
      fall_irq_enable_reg <= diei_pkg::RST_EN;
      irq_vector_reg <= diei_pkg::RST_BYTE;
      debounce_preload_reg <= diei_pkg::RST_BYTE;
    end else if (wr_io) begin
      if (hit(addr, diei_pkg::IDX_GCTL)) begin
        gie_reg <= data_in[diei_pkg::GC_GIE];
        deb_en_reg <= data_in[diei_pkg::GC_DEB];
      end
      if (hit(addr, diei_pkg::IDX_RISE_EN)) begin
        rise_irq_enable_reg <= data_in;
      end
      if (hit(addr, diei_pkg::IDX_FALL_EN)) begin
        fall_irq_enable_reg <= data_in;
      end
      if (hit(addr, diei_pkg::IDX_VEC)) begin
        irq_vector_reg <= data_in[7:0];
      end
      if (hit(addr, diei_pkg::IDX_PRE)) begin
        debounce_preload_reg <= data_in[7:0];
      end
    end
  end

  // Read multiplexer; unmapped words read as zero.
  always_comb begin
    rdata = 16'h0000;
    if (!int_sel_n) begin
      rdata = {8'h00, irq_vector_reg};
    end else begin
      case (addr)
        diei_pkg::IDX_INPUT: rdata = raw_reg;
        diei_pkg::IDX_GCTL: begin
          rdata[diei_pkg::GC_PEND] = any_pend;
          rdata[diei_pkg::GC_DEB] = deb_en_reg;
          rdata[diei_pkg::GC_GIE] = gie_reg;
        end
        diei_pkg::IDX_RISE_EN: rdata = rise_irq_enable_reg;
        diei_pkg::IDX_FALL_EN: rdata = fall_irq_enable_reg;
        diei_pkg::IDX_RISE_PND: rdata = rise_irq_pending_reg;
        diei_pkg::IDX_FALL_PND: rdata = fall_irq_pending_reg;
        diei_pkg::IDX_VEC: rdata = {8'h00, irq_vector_reg};
        diei_pkg::IDX_PRE: rdata = {8'h00, debounce_preload_reg};
        default: rdata = 16'h0000;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Bus cycle: answer one cycle after a select, without wait states.
  // ----------------------------------------------------------------------
  diei_pkg::diei_bus_type bus_reg;   // Bus cycle state.

  assign take = (bus_reg == diei_pkg::DIEI_BUS_IDLE) && (!io_sel_n || !int_sel_n);
  assign wr_io = take && !io_sel_n && int_sel_n && !rd_wr;

  // Sequence: take, one acknowledge cycle, then wait for deselect.
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      bus_reg <= diei_pkg::DIEI_BUS_IDLE;
    end else begin
      case (bus_reg)
        diei_pkg::DIEI_BUS_IDLE: begin
          if (take) begin
            bus_reg <= diei_pkg::DIEI_BUS_ACK;
          end
        end
        diei_pkg::DIEI_BUS_ACK: bus_reg <= diei_pkg::DIEI_BUS_HOLD;
        diei_pkg::DIEI_BUS_HOLD: begin
          if (io_sel_n && int_sel_n) begin
            bus_reg <= diei_pkg::DIEI_BUS_IDLE;
          end
        end
        default: bus_reg <= diei_pkg::DIEI_BUS_IDLE;
      endcase
    end
  end

  // Acknowledge and read data stand for exactly one cycle.
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      ack_n <= 1'b1;
      data_oe <= 1'b0;
      data_out <= 16'h0000;
    end else if (take) begin
      ack_n <= 1'b0;
      data_oe <= rd_wr || !int_sel_n;
      data_out <= (rd_wr || !int_sel_n) ? rdata : 16'h0000;
    end else begin
      ack_n <= 1'b1;
      data_oe <= 1'b0;
      data_out <= 16'h0000;
    end
  end

  // Interrupt line: pending flags gated by the global enable.
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      intreq0_n <= 1'b1;
    end else begin
      intreq0_n <= !(gie_reg && any_pend);
    end
  end

  // ----------------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);

  // A read of global control is taken.
  sequence s_rd_gctl;
    take && !io_sel_n && int_sel_n && rd_wr && hit(addr, diei_pkg::IDX_GCTL);
  endsequence

  // An acknowledge cycle is taken.
  sequence s_iack;
    take && !int_sel_n;
  endsequence

  chk_gie_blocks: assert property (
    !gie_reg ##1 !gie_reg |-> intreq0_n)
    else $error("interrupt line active with global enable off");

  chk_gctl_spare: assert property (s_rd_gctl |=>
    !ack_n && data_out[diei_pkg::GC_SPARE] == 1'b0 && data_out[6:3] == 4'h0)
    else $error("spare control bits not read as zero");

  chk_en_write: assert property (
    wr_io && hit(addr, diei_pkg::IDX_RISE_EN) |=> rise_irq_enable_reg == $past(data_in))
    else $error("rising enable write lost");

  chk_irq_cause: assert property (
    !intreq0_n |-> $past(gie_reg) && $past(any_pend))
    else $error("interrupt line without enable and pending flag");

  chk_reset_clear: assert property (@(posedge mclk) disable iff (1'b0)
    !rstn |=> rise_irq_enable_reg == 16'h0000 && fall_irq_pending_reg == 16'h0000
              && irq_vector_reg == 8'h00 && debounce_preload_reg == 8'h00)
    else $error("registers not cleared by reset");

  chk_w1c_pend: assert property (
    wr_io && hit(addr, diei_pkg::IDX_RISE_PND)
    |=> (rise_irq_pending_reg & $past(data_in) & ~$past(rise_set)) == 16'h0000)
    else $error("acknowledged rising flag not cleared");

  chk_gctl_pend: assert property (s_rd_gctl |=>
    data_out[diei_pkg::GC_PEND] == $past(any_pend) && data_oe)
    else $error("pending summary bit wrong on read");

  chk_edge_sets: assert property (
    |fall_set |=> (fall_irq_pending_reg & $past(fall_set)) == $past(fall_set)
                  ##1 !$past(gie_reg) || !intreq0_n)
    else $error("enabled falling edge did not set pending");

  chk_iack_vec: assert property (s_iack |=>
    !ack_n && data_oe && data_out[7:0] == $past(irq_vector_reg) ##1 ack_n)
    else $error("vector not returned in acknowledge cycle");

endmodule : diei_top

/* testbench.sv */
// Self-checking testbench for the debounced input edge interrupt block.
`timescale 1ns/1ns
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin num_errors++; \
  $display("Error at %0t: got %h expected %h", $time, got, exp); end end
module testbench;
  // ------------------------------------------------------------------
  // Signals.
  // ------------------------------------------------------------------
  localparam int STEP = 20;  // Short debounce step, in register clocks.
  logic mclk, rstn, lclk, io_sel_n, int_sel_n, rd_wr, data_oe, ack_n, intreq0_n;
  logic [5:0] addr;  // Word index of the access.
  logic [15:0] data_in, data_out, din, level, rd;  // Bus words and input levels.
  int num_errors, tests_run;  // Mismatch and comparison counters.

  diei_top #(.STEP_CYC(STEP)) dut_u (.mclk(mclk), .rstn(rstn), .lclk(lclk), .din(din),
    .io_sel_n(io_sel_n), .int_sel_n(int_sel_n), .rd_wr(rd_wr), .addr(addr),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .ack_n(ack_n),
    .intreq0_n(intreq0_n));
  diei_src_model src_u (.lclk(lclk), .level(level), .din(din));

  // ------------------------------------------------------------------
  // Clocks: the link clock runs with an odd offset to the register clock.
  // ------------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  initial begin
    lclk = 1'b0;
    #7;
    forever #40 lclk = ~lclk;
  end

  // ------------------------------------------------------------------
  // Bus tasks: one cycle held until the acknowledge is seen.
  // ------------------------------------------------------------------
  task automatic bus(input logic ia, input logic rw, input logic [5:0] a,
                     input logic [15:0] wd, output logic [15:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    #1;
    io_sel_n = ia;
    int_sel_n = ~ia;
    rd_wr = rw;
    addr = a;
    data_in = wd;
    do begin
      @(posedge mclk);
      #1;
      n++;
    end while (ack_n !== 1'b0 && n < 8);
    d = data_out;
    `CHK(ack_n, 1'b0)
    `CHK(data_oe, rw)
    @(posedge mclk);
    #1;
    io_sel_n = 1'b1;
    int_sel_n = 1'b1;
  endtask : bus
  task automatic wr(input logic [5:0] a, input logic [15:0] wd);
    bus(1'b0, 1'b0, a, wd, rd);
  endtask : wr
  task automatic rdc(input logic [5:0] a, input logic [15:0] exp);
    bus(1'b0, 1'b1, a, 16'h0000, rd);
    `CHK(rd, exp)
  endtask : rdc
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : wait_cyc

  // ------------------------------------------------------------------
  // Verdict, reached from the main sequence and from the watchdog.
  // ------------------------------------------------------------------
  task automatic stop_test();
    if (num_errors == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test
  initial begin
    #(40 * 20000);
    num_errors++;
    stop_test();
  end

  // ------------------------------------------------------------------
  // Main sequence.
  // ------------------------------------------------------------------
  initial begin
    num_errors = 0;
    tests_run = 0;
    rstn = 1'b0;
    {io_sel_n, int_sel_n, rd_wr} = 3'b111;
    addr = 6'h00;
    data_in = 16'h0000;
    level = 16'h0000;
    repeat (8) @(posedge mclk);
    #1;
    rstn = 1'b1;
    for (int i = 1; i < 9; i++) rdc(i[5:0], 16'h0000);
    `CHK(intreq0_n, 1'b1)
    wr(diei_pkg::IDX_VEC, 16'hff7e);
    rdc(diei_pkg::IDX_VEC, 16'h007e);
    wr(diei_pkg::IDX_RISE_EN, 16'h0005);
    rdc(diei_pkg::IDX_RISE_EN, 16'h0005);
    wr(diei_pkg::IDX_FALL_EN, 16'h0002);
    rdc(diei_pkg::IDX_FALL_EN, 16'h0002);
    level = 16'h000f;
    wait_cyc(30);
    rdc(diei_pkg::IDX_INPUT, 16'h000f);
    rdc(diei_pkg::IDX_RISE_PND, 16'h0005);
    `CHK(intreq0_n, 1'b1)
    wr(diei_pkg::IDX_GCTL, 16'h0003);
    rdc(diei_pkg::IDX_GCTL, 16'h0081);
    `CHK(intreq0_n, 1'b0)
    bus(1'b1, 1'b1, 6'h00, 16'h0000, rd);
    `CHK(rd, 16'h007e)
    wr(diei_pkg::IDX_RISE_PND, 16'h0001);
    rdc(diei_pkg::IDX_RISE_PND, 16'h0004);
    `CHK(intreq0_n, 1'b0)
    wr(diei_pkg::IDX_RISE_PND, 16'h0004);
    rdc(diei_pkg::IDX_GCTL, 16'h0001);
    `CHK(intreq0_n, 1'b1)
    level = 16'h0000;
    wait_cyc(30);
    rdc(diei_pkg::IDX_FALL_PND, 16'h0002);
    `CHK(intreq0_n, 1'b0)
    wr(diei_pkg::IDX_GCTL, 16'h0000);
    wait_cyc(2);
    `CHK(intreq0_n, 1'b1)
    wr(diei_pkg::IDX_FALL_PND, 16'h0002);
    rdc(diei_pkg::IDX_FALL_PND, 16'h0000);
    wr(diei_pkg::IDX_RISE_EN, 16'hffff);
    wr(diei_pkg::IDX_PRE, 16'h0003);
    rdc(diei_pkg::IDX_PRE, 16'h0003);
    wr(diei_pkg::IDX_GCTL, 16'h0005);
    level = 16'h8011;
    wait_cyc(40);
    rdc(diei_pkg::IDX_RISE_PND, 16'h0000);
    wait_cyc(90);
    rdc(diei_pkg::IDX_RISE_PND, 16'h8011);
    // Second reset with registers loaded and inputs 0, 4 and 15 held high.
    rstn = 1'b0;
    wait_cyc(8);
    rstn = 1'b1;
    rdc(diei_pkg::IDX_RISE_EN, 16'h0000);
    rdc(diei_pkg::IDX_VEC, 16'h0000);
    rdc(diei_pkg::IDX_PRE, 16'h0000);
    wait_cyc(30);
    rdc(diei_pkg::IDX_INPUT, 16'h8011);
    rdc(diei_pkg::IDX_RISE_PND, 16'h0000);
    `CHK(intreq0_n, 1'b1)
    stop_test();
  end
endmodule : testbench
